/* File: inc/two_wire_defs.svh */
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH
// What this block does
// - transaction opens with start, then address byte
// - device answers 0xba for write, 0xbb read
// - device acknowledges its own address byte
// - write sends pointer next; device acknowledges it
// - device acknowledges every written data byte
// - register written only after both bytes arrive
// - pointer advances after each written word
// - master ends write with start or stop
// - read: pointer write, restart, read address
// - device shifts bytes out; master acknowledges each but the last
// - pointer advances after each word read
// - master nacks last byte; device releases line
// - bus idle when clock and data high
// - only master makes start and stop
// - start is data falling while clock high
// - stop is data rising while clock high
// - master supplies clock, one bit per pulse
// - data changes only while clock low
// - transmitter releases, receiver pulls low to acknowledge
// - released acknowledge slot means no-acknowledge
// - open-drain data: only pull low or release

////////////////////////////////////////////////////////////////
// slave address, joined with the direction bit on the wire
`define DEV_SLAVE_ADDR 7'h5d
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1

// bit slot numbers inside one nine-slot byte frame
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8

////////////////////////////////////////////////////////////////
// timing
`define SYS_PERIOD_NS 10
`define SCL_PERIOD_NS 10000
`define QTR_CYC ((`SCL_PERIOD_NS / 4) / `SYS_PERIOD_NS)
`define QCNT_W 12

`endif

/* File: inc/two_wire_pkg.sv */
package two_wire_pkg;

  typedef enum logic [2:0] {
    DS_ADDR = 3'h0,
    DS_PTR = 3'h1,
    DS_WDATA = 3'h3,
    DS_RDATA = 3'h2,
    DS_IDLE = 3'h6
  } dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_START = 2'h1,
    HS_BYTE = 2'h3,
    HS_STOP = 2'h2
  } host_state_t;

  typedef enum logic [2:0] {
    SG_AW = 3'h0,
    SG_PTR = 3'h1,
    SG_WDAT = 3'h3,
    SG_AR = 3'h2,
    SG_RDAT = 3'h6
  } host_stage_t;

endpackage

/* File: inc/two_wire_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
  logic serial_clk;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic bus_data_pin;

  // external pull-up: line is high unless a party pulls it low
  assign bus_data_pin = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport host (
    output serial_clk,
    output host_sda_out,
    output host_sda_oe,
    input bus_data_pin
  );

  modport device (
    input serial_clk,
    input bus_data_pin,
    output dev_sda_out,
    output dev_sda_oe
  );
endinterface
`default_nettype wire

/* File: logic/two_wire_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module two_wire_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] stable_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= d_in;
      stable_reg <= meta_reg;
    end
  end

  assign q_out = stable_reg;
endmodule
`default_nettype wire

/* File: logic/two_wire_dev_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.svh"
module two_wire_dev_end
  import two_wire_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // link
  two_wire_if.device link,
  // register write port
  output logic wr_valid_out,
  output logic [7:0] wr_addr_out,
  output logic [15:0] wr_data_out,
  // register read port
  output logic rd_strobe_out,
  output logic [7:0] rd_addr_out,
  input wire logic [15:0] rd_data_in,
  // status
  output logic bus_idle_out
);

  ////////////////////////////////////////////////////////////////
  // link domain declarations

  logic start_tog_reg;
  logic stop_tog_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  dev_state_t state_reg;
  dev_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [6:0] shift_reg;
  logic ack_reg;
  logic ack_next;
  logic half_reg;
  logic half_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] hi_reg;
  logic [7:0] wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic wr_tog_reg;
  logic rd_tog_reg;
  logic oe_reg;
  logic oe_next;

  logic new_start;
  logic new_stop;
  logic [7:0] in_byte;
  logic at_last;
  logic at_ack;
  logic addr_hit;
  logic take_addr;
  logic take_ptr;
  logic take_data;
  logic give_data;
  logic word_done;
  logic master_nack;
  logic [7:0] tx_byte;
  logic tx_bit;

  ////////////////////////////////////////////////////////////////
  // system domain declarations

  logic [3:0] sync_q;
  logic wr_tog_s;
  logic rd_tog_s;
  logic scl_s;
  logic sda_s;
  logic wr_seen_reg;
  logic rd_seen_reg;
  logic wr_valid_reg;
  logic [7:0] out_addr_reg;
  logic [15:0] out_data_reg;
  logic rd_strobe_reg;
  logic [7:0] rd_addr_reg;
  logic [15:0] rd_word_reg;
  logic idle_reg;

  ////////////////////////////////////////////////////////////////
  // start and stop detection, clocked by the data line itself
  // the device only moves the line while the clock is low, so it can
  // never trip these flops itself

  always_ff @(negedge link.bus_data_pin or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_tog_reg <= 1'b0;
    end else if (link.serial_clk) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  always_ff @(posedge link.bus_data_pin or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_tog_reg <= 1'b0;
    end else if (link.serial_clk) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive decoding on the rising clock edge

  assign new_start = start_tog_reg != start_seen_reg;
  assign new_stop = stop_tog_reg != stop_seen_reg;
  assign in_byte = {shift_reg, link.bus_data_pin};
  assign at_last = (cnt_reg == `BIT_LAST) && !new_start;
  assign at_ack = (cnt_reg == `BIT_ACK) && !new_start;
  assign addr_hit = in_byte[7:1] == `DEV_SLAVE_ADDR;
  assign take_addr = at_last && (state_reg == DS_ADDR);
  assign take_ptr = at_last && (state_reg == DS_PTR);
  assign take_data = at_last && (state_reg == DS_WDATA);
  assign give_data = at_last && (state_reg == DS_RDATA);
  assign word_done = (take_data || give_data) && half_reg;
  assign master_nack = at_ack && (state_reg == DS_RDATA) && link.bus_data_pin;

  always_comb begin
    state_next = state_reg;
    if (new_start) begin
      state_next = DS_ADDR;
    end else if (new_stop) begin
      state_next = DS_IDLE;
    end else if (take_addr) begin
      if (!addr_hit) begin
        state_next = DS_IDLE;
      end else if (in_byte[0] == `DIR_READ) begin
        state_next = DS_RDATA;
      end else begin
        state_next = DS_PTR;
      end
    end else if (take_ptr) begin
      state_next = DS_WDATA;
    end else if (master_nack) begin
      state_next = DS_IDLE;
    end
  end

  // the edge that sees a fresh start already carries address bit 7
  assign cnt_next = new_start ? 4'h1 : ((cnt_reg == `BIT_ACK) ? 4'h0 : cnt_reg + 4'h1);
  assign ack_next = at_last && !new_stop && ((take_addr && addr_hit)
    || state_reg == DS_PTR || state_reg == DS_WDATA);
  assign half_next = (take_addr || take_ptr) ? 1'b0
    : ((take_data || give_data) ? ~half_reg : half_reg);
  assign ptr_next = take_ptr ? in_byte : (word_done ? ptr_reg + 8'h01 : ptr_reg);

  always_ff @(posedge link.serial_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= DS_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      ack_reg <= 1'b0;
      half_reg <= 1'b0;
      ptr_reg <= 8'h00;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= new_start ? {6'h00, link.bus_data_pin} : in_byte[6:0];
      ack_reg <= ack_next;
      half_reg <= half_next;
      ptr_reg <= ptr_next;
      start_seen_reg <= start_tog_reg;
      stop_seen_reg <= stop_tog_reg;
    end
  end

  // a word reaches the system side only once both bytes are in
  always_ff @(posedge link.serial_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_reg <= 8'h00;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 16'h0000;
      wr_tog_reg <= 1'b0;
    end else if (take_data && !half_reg) begin
      hi_reg <= in_byte;
    end else if (take_data) begin
      wr_addr_reg <= ptr_reg;
      wr_data_reg <= {hi_reg, in_byte};
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // prefetch whenever the pointer moves, so the word is ready before
  // the next read byte starts
  always_ff @(posedge link.serial_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_tog_reg <= 1'b0;
    end else if (take_ptr || word_done) begin
      rd_tog_reg <= ~rd_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit on the falling clock edge

  assign tx_byte = half_reg ? rd_word_reg[7:0] : rd_word_reg[15:8];
  assign tx_bit = tx_byte[3'(`BIT_LAST - cnt_reg)];
  assign oe_next = ((cnt_reg == `BIT_ACK) && ack_reg)
    || ((state_reg == DS_RDATA) && (cnt_reg != `BIT_ACK) && !tx_bit);

  always_ff @(negedge link.serial_clk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = oe_reg;

  ////////////////////////////////////////////////////////////////
  // system side: events cross as toggles, the words beside them are
  // held still by the protocol for many link clocks

  two_wire_sync #(
    .W(4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in({wr_tog_reg, rd_tog_reg, link.serial_clk, link.bus_data_pin}),
    .q_out(sync_q)
  );

  assign wr_tog_s = sync_q[3];
  assign rd_tog_s = sync_q[2];
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_seen_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      out_addr_reg <= 8'h00;
      out_data_reg <= 16'h0000;
    end else begin
      wr_seen_reg <= wr_tog_s;
      wr_valid_reg <= wr_tog_s != wr_seen_reg;
      if (wr_tog_s != wr_seen_reg) begin
        out_addr_reg <= wr_addr_reg;
        out_data_reg <= wr_data_reg;
      end
    end
  end

  // limitation: the system clock must run several times faster than the
  // link clock, or the next word of a read is not fetched in time
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_seen_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      rd_word_reg <= 16'h0000;
    end else begin
      rd_seen_reg <= rd_tog_s;
      rd_strobe_reg <= rd_tog_s != rd_seen_reg;
      if (rd_tog_s != rd_seen_reg) begin
        rd_addr_reg <= ptr_reg;
      end
      if (rd_strobe_reg) begin
        rd_word_reg <= rd_data_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_reg <= 1'b0;
    end else begin
      idle_reg <= scl_s && sda_s;
    end
  end

  assign wr_valid_out = wr_valid_reg;
  assign wr_addr_out = out_addr_reg;
  assign wr_data_out = out_data_reg;
  assign rd_strobe_out = rd_strobe_reg;
  assign rd_addr_out = rd_addr_reg;
  assign bus_idle_out = idle_reg;
endmodule
`default_nettype wire

/* File: logic/two_wire_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.svh"
module two_wire_host_end
  import two_wire_pkg::*;
#(
  parameter int QTR_CYC = `QTR_CYC
) (
  // system clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // link
  two_wire_if.host link,
  // command
  input wire logic cmd_valid_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_ptr_in,
  input wire logic [7:0] cmd_words_in,
  output logic cmd_ready_out,
  // write words
  input wire logic [15:0] wdata_in,
  output logic wdata_take_out,
  // read words and status
  output logic [15:0] rdata_out,
  output logic rdata_valid_out,
  output logic nack_out
);

  host_state_t state_reg;
  host_stage_t stage_reg;
  logic [`QCNT_W-1:0] qcnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] txb_reg;
  logic [7:0] rxb_reg;
  logic [8:0] left_reg;
  logic read_reg;
  logic [7:0] ptr_reg;
  logic [15:0] word_reg;
  logic scl_reg;
  logic low_reg;
  logic ackbit_reg;
  logic nack_reg;
  logic take_reg;
  logic rvalid_reg;
  logic [15:0] rdata_reg;

  logic sda_s;
  logic tick;
  logic tx_mode;
  logic low_bit;
  logic is_ack;

  ////////////////////////////////////////////////////////////////
  // quarter-period timer; the link clock is divided from the system clock

  two_wire_sync #(
    .W(1)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in(link.bus_data_pin),
    .q_out(sda_s)
  );

  assign tick = qcnt_reg == `QCNT_W'(QTR_CYC - 1);
  assign is_ack = bit_reg == `BIT_ACK;
  assign tx_mode = stage_reg != SG_RDAT;
  // last read byte gets no pull, which the device sees as a nack
  assign low_bit = is_ack ? (!tx_mode && left_reg != 9'h001)
    : (tx_mode && !txb_reg[7]);
  assign cmd_ready_out = (state_reg == HS_IDLE) && sda_s && scl_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qcnt_reg <= '0;
    end else if (state_reg == HS_IDLE || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + `QCNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus sequencer: quarter 0 moves data with the clock low, quarter 1
  // raises the clock, quarter 2 samples, quarter 3 lowers the clock

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= HS_IDLE;
      stage_reg <= SG_AW;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      txb_reg <= 8'h00;
      rxb_reg <= 8'h00;
      left_reg <= 9'h000;
      read_reg <= 1'b0;
      ptr_reg <= 8'h00;
      word_reg <= 16'h0000;
      scl_reg <= 1'b1;
      low_reg <= 1'b0;
      ackbit_reg <= 1'b0;
      nack_reg <= 1'b0;
      take_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      take_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      if (state_reg == HS_IDLE) begin
        if (cmd_valid_in && cmd_ready_out) begin
          state_reg <= HS_START;
          stage_reg <= SG_AW;
          phase_reg <= 2'h0;
          read_reg <= cmd_read_in;
          ptr_reg <= cmd_ptr_in;
          left_reg <= {cmd_words_in, 1'b0};
          txb_reg <= {`DEV_SLAVE_ADDR, `DIR_WRITE};
          nack_reg <= 1'b0;
        end
      end else if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        unique case (state_reg)
          HS_IDLE: begin
          end
          HS_START: begin
            if (phase_reg == 2'h0) low_reg <= 1'b0;
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h2) low_reg <= 1'b1;
            if (phase_reg == 2'h3) begin
              scl_reg <= 1'b0;
              bit_reg <= 4'h0;
              state_reg <= HS_BYTE;
            end
          end
          HS_STOP: begin
            if (phase_reg == 2'h0) low_reg <= 1'b1;
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h2) low_reg <= 1'b0;
            if (phase_reg == 2'h3) state_reg <= HS_IDLE;
          end
          HS_BYTE: begin
            if (phase_reg == 2'h0) low_reg <= low_bit;
            if (phase_reg == 2'h1) scl_reg <= 1'b1;
            if (phase_reg == 2'h2 && is_ack) ackbit_reg <= sda_s;
            if (phase_reg == 2'h2 && !is_ack) rxb_reg <= {rxb_reg[6:0], sda_s};
            if (phase_reg == 2'h3) begin
              scl_reg <= 1'b0;
              if (!is_ack) begin
                bit_reg <= bit_reg + 4'h1;
                txb_reg <= {txb_reg[6:0], 1'b0};
              end else begin
                bit_reg <= 4'h0;
                if (tx_mode && ackbit_reg) begin
                  nack_reg <= 1'b1;
                  state_reg <= HS_STOP;
                end else begin
                  unique case (stage_reg)
                    SG_AW: begin
                      txb_reg <= ptr_reg;
                      stage_reg <= SG_PTR;
                    end
                    SG_PTR: begin
                      if (left_reg == 9'h000) begin
                        state_reg <= HS_STOP;
                      end else if (read_reg) begin
                        stage_reg <= SG_AR;
                        txb_reg <= {`DEV_SLAVE_ADDR, `DIR_READ};
                        state_reg <= HS_START;
                      end else begin
                        word_reg <= wdata_in;
                        take_reg <= 1'b1;
                        txb_reg <= wdata_in[15:8];
                        stage_reg <= SG_WDAT;
                      end
                    end
                    SG_WDAT: begin
                      left_reg <= left_reg - 9'h001;
                      if (left_reg == 9'h001) begin
                        state_reg <= HS_STOP;
                      end else if (!left_reg[0]) begin
                        txb_reg <= word_reg[7:0];
                      end else begin
                        word_reg <= wdata_in;
                        take_reg <= 1'b1;
                        txb_reg <= wdata_in[15:8];
                      end
                    end
                    SG_AR: begin
                      stage_reg <= SG_RDAT;
                    end
                    SG_RDAT: begin
                      left_reg <= left_reg - 9'h001;
                      if (!left_reg[0]) begin
                        word_reg[15:8] <= rxb_reg;
                      end else begin
                        rdata_reg <= {word_reg[15:8], rxb_reg};
                        rvalid_reg <= 1'b1;
                      end
                      if (left_reg == 9'h001) state_reg <= HS_STOP;
                    end
                    default: begin
                      state_reg <= HS_STOP;
                    end
                  endcase
                end
              end
            end
          end
        endcase
      end
    end
  end

  assign link.serial_clk = scl_reg;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = low_reg;
  assign wdata_take_out = take_reg;
  assign rdata_out = rdata_reg;
  assign rdata_valid_out = rvalid_reg;
  assign nack_out = nack_reg;
endmodule
`default_nettype wire

/* File: test/two_wire_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.svh"
module two_wire_properties (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // link signals
  input wire logic serial_clk,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic bus_data_pin
);
  logic scl_reg;
  logic pin_reg;
  logic dir_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [1:0] byte_reg;
  wire scl_rise = serial_clk && !scl_reg;
  wire start_seen = serial_clk && scl_reg && pin_reg && !bus_data_pin;
  wire ack_slot = scl_rise && bit_reg == 4'h8;
  wire ours = sh_reg[7:1] == `DEV_SLAVE_ADDR;
  ////////////////////////////////////////////////////////////////
  // bit and byte tracking; restarts reset the count
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_reg <= 1'b1;
      pin_reg <= 1'b1;
      dir_reg <= 1'b0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      byte_reg <= 2'h0;
    end else begin
      scl_reg <= serial_clk;
      pin_reg <= bus_data_pin;
      if (start_seen) begin
        bit_reg <= 4'h0;
        byte_reg <= 2'h0;
      end else if (ack_slot) begin
        bit_reg <= 4'h0;
        byte_reg <= byte_reg + {1'b0, byte_reg != 2'h3};
        if (byte_reg == 2'h0) dir_reg <= sh_reg[0];
      end else if (scl_rise) begin
        bit_reg <= bit_reg + 4'h1;
        sh_reg <= {sh_reg[6:0], bus_data_pin};
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_dev_pull_only: assert property (!dev_sda_out)
    else $error("device drives data high");
  chk_host_pull_only: assert property (!host_sda_out)
    else $error("host drives data high");
  chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !serial_clk)
    else $error("device data moved with clock high");
  chk_one_driver_high: assert property (serial_clk |-> !(host_sda_oe && dev_sda_oe))
    else $error("both parties pull while clock high");
  chk_scl_low_time: assert property ($fell(serial_clk) |-> !serial_clk [*8])
    else $error("clock low phase too short");
  chk_scl_high_time: assert property ($rose(serial_clk) |-> serial_clk [*8])
    else $error("clock high phase too short");
  chk_addr_ack_low: assert property (ack_slot && byte_reg == 2'h0 && ours |-> !bus_data_pin)
    else $error("own address not acknowledged");
  chk_write_ack_low: assert property (ack_slot && byte_reg != 2'h0 && !dir_reg |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  chk_read_ack_free: assert property (ack_slot && byte_reg != 2'h0 && dir_reg |-> !dev_sda_oe)
    else $error("device holds line in master ack slot");
  cov_start: cover property (start_seen);
  cov_write_ack: cover property (ack_slot && !dir_reg && byte_reg == 2'h2);
  cov_read_ack: cover property (ack_slot && dir_reg && byte_reg == 2'h2);
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_n_in;
  logic cmd_valid_in = 1'b0;
  logic cmd_read_in = 1'b0;
  logic [7:0] cmd_ptr_in = 8'h00;
  logic [7:0] cmd_words_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic [15:0] rdata_out, wr_data_out, rd_data_in;
  logic [7:0] wr_addr_out, rd_addr_out, sh;
  logic cmd_ready_out, wdata_take_out, rdata_valid_out, nack_out;
  logic wr_valid_out, rd_strobe_out, bus_idle_out, b_wr_valid;
  logic [15:0] regs [256];
  logic [23:0] wr_q [$];
  logic [23:0] rd_q [$];
  logic [23:0] addr_q [$];
  int bit_n = 9;
  int b_writes = 0;
  int bad_count = 0;
  int samples_checked = 0;
  two_wire_if link ();
  two_wire_if link_b ();
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////
  two_wire_host_end #(.QTR_CYC(4)) u_two_wire_host_end (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .link(link.host), .cmd_valid_in(cmd_valid_in), .cmd_read_in(cmd_read_in), .cmd_ptr_in(cmd_ptr_in),
    .cmd_words_in(cmd_words_in), .cmd_ready_out(cmd_ready_out), .wdata_in(wdata_in),
    .wdata_take_out(wdata_take_out), .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
    .nack_out(nack_out));
  two_wire_dev_end u_two_wire_dev_end (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(link.device),
    .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .rd_strobe_out(rd_strobe_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
    .bus_idle_out(bus_idle_out));
  // second device faces a bench driver that breaks the protocol
  two_wire_dev_end u_two_wire_dev_end_b (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .link(link_b.device), .wr_valid_out(b_wr_valid), .wr_addr_out(), .wr_data_out(),
    .rd_strobe_out(), .rd_addr_out(), .rd_data_in(16'h0000), .bus_idle_out());
  two_wire_properties u_two_wire_properties (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .serial_clk(link.serial_clk), .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .bus_data_pin(link.bus_data_pin));
  ////////////////////////////////////////////////////////////////
  // register file behind the device; read data is combinational
  assign rd_data_in = regs[rd_addr_out];
  always @(posedge clk_sys_in) begin
    if (wr_valid_out === 1'b1) begin
      wr_q.push_back({wr_addr_out, wr_data_out});
      regs[wr_addr_out] = wr_data_out;
    end
    if (rdata_valid_out === 1'b1) rd_q.push_back({8'h00, rdata_out});
    if (b_wr_valid === 1'b1) b_writes++;
  end
  // first byte after each start, as seen on the wire
  always @(negedge link.bus_data_pin) if (link.serial_clk === 1'b1) bit_n = 0;
  always @(posedge link.serial_clk) begin
    if (bit_n < 8) begin
      sh = {sh[6:0], link.bus_data_pin};
      bit_n++;
      if (bit_n == 8) addr_q.push_back({16'h0000, sh});
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run_cmd(input logic rd, input logic [7:0] ptr, input logic [7:0] n, input logic [15:0] w0,
                         input logic [15:0] w1);
    int k;
    k = 0;
    cmd_valid_in <= 1'b1;
    cmd_read_in <= rd;
    cmd_ptr_in <= ptr;
    cmd_words_in <= n;
    wdata_in <= w0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (cmd_ready_out !== 1'b1 && k < 50);
    cmd_valid_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    for (k = 0; k < 8000 && cmd_ready_out !== 1'b1; k++) begin
      @(posedge clk_sys_in);
      if (wdata_take_out === 1'b1) wdata_in <= w1;
    end
    chk({23'h0, cmd_ready_out}, 24'h1);
    chk({23'h0, nack_out}, 24'h0);
  endtask
  // bench driver steps last four system cycles each
  task automatic bb_set(input logic scl, input logic oe);
    link_b.serial_clk <= scl;
    link_b.host_sda_oe <= oe;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic bb_byte(input logic [8:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      bb_set(1'b0, link_b.host_sda_oe);
      bb_set(1'b0, !b[i]);
      bb_set(1'b1, !b[i]);
      ack = link_b.bus_data_pin;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic a;
    rst_n_in <= 1'b0;
    link_b.serial_clk = 1'b1;
    link_b.host_sda_out = 1'b0;
    link_b.host_sda_oe = 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = {~8'(i), 8'(i)};
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    run_cmd(1'b0, 8'hff, 8'h02, 16'h0284, 16'ha5c3);
    chk(addr_q.pop_front(), 24'h0000ba);
    chk(24'(wr_q.size()), 24'h2);
    chk(wr_q.pop_front(), 24'hff0284);
    chk(wr_q.pop_front(), 24'h00a5c3);
    $display("write test done");
    run_cmd(1'b1, 8'hff, 8'h02, 16'h0000, 16'h0000);
    chk(addr_q.pop_front(), 24'h0000ba);
    chk(addr_q.pop_front(), 24'h0000bb);
    chk(rd_q.pop_front(), 24'h000284);
    chk(rd_q.pop_front(), 24'h00a5c3);
    run_cmd(1'b1, 8'h40, 8'h03, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) chk(rd_q.pop_front(), {8'h00, ~8'(64 + i), 8'(64 + i)});
    repeat (4) @(posedge clk_sys_in);
    chk({23'h0, bus_idle_out}, 24'h1);
    $display("read test done");
    // pointer-only write leaves every register alone
    run_cmd(1'b0, 8'h30, 8'h00, 16'h1234, 16'h1234);
    chk(24'(wr_q.size()), 24'h0);
    $display("pointer test done");
    bb_set(1'b1, 1'b1);
    bb_byte({8'hb8, 1'b1}, a);
    chk({23'h0, a}, 24'h1);
    bb_byte({8'hba, 1'b1}, a);
    chk({23'h0, a}, 24'h1);
    bb_set(1'b0, 1'b1);
    bb_set(1'b1, 1'b1);
    bb_set(1'b1, 1'b0);
    bb_set(1'b1, 1'b1);
    bb_byte({8'hba, 1'b1}, a);
    chk({23'h0, a}, 24'h0);
    bb_byte({8'h10, 1'b1}, a);
    chk({23'h0, a}, 24'h0);
    bb_byte({8'h55, 1'b1}, a);
    chk({23'h0, a}, 24'h0);
    bb_set(1'b0, 1'b1);
    bb_set(1'b1, 1'b1);
    bb_set(1'b1, 1'b0);
    repeat (40) @(posedge clk_sys_in);
    chk(24'(b_writes), 24'h0);
    $display("fault test done");
    close_out();
  end
  // whole run is near 4300 cycles
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
